// [bench/host_model.sv]
`timescale 1ns/1ps
// host side of the register port, drives on falling edges
module host_model (
	input wire logic clk_sys,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// released lines show inverted values so stale data never matches
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk_sys);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask

	// data sampled a cycle and a half after the read edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk_sys);
		reg_rd = 1'b0;
		reg_addr = ~a;
		@(negedge clk_sys);
		d = reg_rdata;
	endtask
endmodule // host_model

// [bench/regulator_mode_and_poweroff_config_test.sv]
`timescale 1ns/1ps
module regulator_mode_and_poweroff_config_test;
	logic clk_sys, sys_rst, reg_wr, reg_rd, shutdown_req, rails_restore;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, got, cfg;
	logic [1:0] am, af, bm, bf, cm, cf, aw, bw, cw, lh, ll, step;
	logic ph, a_off, b_off, c_off, busy, done;
	logic [7:0] shadow [12];
	int fails, samples_checked, cycles, seed, n, lo;

	regulator_mode_and_poweroff_config #(.DUAL_PHASE_DEFAULT(1'b1),
		.MS_CYCLES(10)) dut_u (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .shutdown_req(shutdown_req),
		.rails_restore(rails_restore), .buck_a_conduction_mode(am),
		.buck_a_frequency(af), .buck_b_conduction_mode(bm),
		.buck_b_frequency(bf), .buck_c_conduction_mode(cm),
		.buck_c_frequency(cf), .phase_combine(ph),
		.buck_a_warn_threshold(aw), .buck_b_warn_threshold(bw),
		.buck_c_warn_threshold(cw), .linear_high_voltage_select(lh),
		.linear_low_voltage_select(ll), .buck_a_off(a_off),
		.buck_b_off(b_off), .buck_c_off(c_off), .shutdown_busy(busy),
		.shutdown_done(done), .shutdown_step(step));

	host_model host_u (.clk_sys(clk_sys), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// hang guard, whole run needs under a thousand cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			stop_test();
		end
	end

	// expected reset value per slot 0x4D + i
	function automatic logic [7:0] rst_val(input int i);
		case (i)
			0: return 8'h80;
			1: return 8'h88;
			2: return 8'h01;
			3: return 8'hCF;
			4: return 8'h42;
			11: return 8'hD1;
			default: return 8'h00;
		endcase
	endfunction

	// writable bits per slot, reserved slots hold nothing
	function automatic logic [7:0] wmask(input int i);
		case (i)
			0: return 8'hF0;
			1: return 8'hFF;
			2: return 8'h01;
			3: return 8'hCF;
			4: return 8'hC6;
			11: return 8'hDF;
			default: return 8'h00;
		endcase
	endfunction

	task automatic err(input string m);
		fails++;
		$display("Error at %0t: %s", $time, m);
	endtask

	task automatic chk(input logic [7:0] g, e, input string m);
		samples_checked++;
		if (g !== e) err(m);
	endtask

	task automatic fields;
		chk({am, af, 4'h0}, shadow[0], "buck a fields");
		chk({bm, bf, cm, cf}, shadow[1], "buck b c fields");
		chk({7'h0, ph}, shadow[2], "phase combine");
		chk({aw, 2'h0, bw, cw}, shadow[3], "warn levels");
		chk({lh, 3'h0, ll, 1'h0}, shadow[4], "linear levels");
	endtask

	// one-cycle strobe; an argument copy would only land after return
	task automatic pulse(input logic restore);
		@(negedge clk_sys);
		if (restore) begin
			rails_restore = 1'b1;
		end else begin
			shutdown_req = 1'b1;
		end
		@(negedge clk_sys);
		rails_restore = 1'b0;
		shutdown_req = 1'b0;
	endtask

	// one power-off run; later steps are skipped
	task automatic seq(input logic [7:0] c);
		host_u.wr(8'h58, c);
		pulse(1'b0);
		chk({5'h0, busy, step}, 8'h04, "sequence start");
		n = 1;
		while (done !== 1'b1 && n < 200) begin
			@(negedge clk_sys);
			n++;
		end
		lo = c[7] ? c[2:0] * 10 + 2 : 2;
		samples_checked++;
		if (n < lo || n > lo + 6) err("sequence length");
		cfg = c[7] ? {5'h0, c[6], c[4], c[3]} : 8'h00;
		chk({5'h0, a_off, b_off, c_off}, cfg, "rails off");
		chk({5'h0, done, step}, 8'h06, "ended at last step");
		pulse(1'b0);
		@(negedge clk_sys);
		chk({6'h0, busy, done}, 8'h01, "req while done");
		pulse(1'b1);
		@(negedge clk_sys);
		chk({4'h0, a_off, b_off, c_off, done}, 8'h00, "restore");
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		seed = 32'hfde255e3;
		sys_rst = 1'b1;
		shutdown_req = 1'b0;
		rails_restore = 1'b0;
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys);
		sys_rst = 1'b0;
		for (int i = 0; i < 12; i++) begin
			shadow[i] = rst_val(i);
			host_u.rd(8'h4D + i[7:0], got);
			chk(got, shadow[i], "reset value");
		end
		fields();
		$display("reset test done");
		// random writes, reserved bytes and bits among them
		repeat (80) begin
			n = {$random(seed)} % 12;
			cfg = 8'($random(seed));
			host_u.wr(8'h4D + n[7:0], cfg);
			shadow[n] = cfg & wmask(n);
			host_u.rd(8'h4D + n[7:0], got);
			chk(got, shadow[n], "readback");
			fields();
		end
		host_u.wr(8'h60, 8'hFF);
		host_u.rd(8'h60, got);
		chk(got, 8'h00, "unmapped read");
		$display("register test done");
		host_u.wr(8'h59, 8'h00);
		host_u.wr(8'h5A, 8'h00);
		seq(8'hD8);
		seq(8'h97);
		seq(8'h5B);
		repeat (4) seq(8'($random(seed)));
		// only the last step runs, so its own byte must drive the rails
		host_u.wr(8'h58, 8'h00);
		host_u.wr(8'h5A, 8'h89);
		pulse(1'b0);
		repeat (20) @(negedge clk_sys);
		chk({4'h0, a_off, b_off, c_off, done}, 8'h03, "last step");
		pulse(1'b1);
		$display("sequence test done");
		// reset in mid-wait must drop everything
		host_u.wr(8'h58, 8'hD2);
		pulse(1'b0);
		repeat (5) @(negedge clk_sys);
		sys_rst = 1'b1;
		@(negedge clk_sys);
		chk({4'h0, a_off, b_off, c_off, busy}, 8'h00, "reset mid run");
		sys_rst = 1'b0;
		host_u.rd(8'h58, got);
		chk(got, 8'hD1, "step0 after reset");
		$display("mid reset test done");
		stop_test();
	end
endmodule // regulator_mode_and_poweroff_config_test

// [logic/pmic_cfg_pkg.sv]
package pmic_cfg_pkg;
	localparam logic [7:0] OFS_BUCK_A_MODE_FREQ = 8'h4D;
	localparam logic [7:0] OFS_BUCK_BC_MODE_FREQ = 8'h4E;
	localparam logic [7:0] OFS_PHASE_COMBINE = 8'h4F;
	localparam logic [7:0] OFS_CURRENT_WARN = 8'h50;
	localparam logic [7:0] OFS_LINEAR_VOLTAGE = 8'h51;
	localparam logic [7:0] OFS_RSVD_FIRST = 8'h52;
	localparam logic [7:0] OFS_RSVD_LAST = 8'h57;
	localparam logic [7:0] OFS_SHUTDOWN_STEP0 = 8'h58;
	localparam logic [7:0] OFS_SHUTDOWN_STEP1 = 8'h59;
	localparam logic [7:0] OFS_SHUTDOWN_STEP2 = 8'h5A;
	// storage slots, in offset order
	localparam int NUM_REGS = 8;
	localparam logic [2:0] SLOT_STEP0 = 3'h5;
	localparam logic [1:0] LAST_STEP = 2'h2;
	// field positions (low bit of each field)
	localparam int POS_A_MODE = 6;
	localparam int POS_A_FREQ = 4;
	localparam int POS_B_MODE = 6;
	localparam int POS_B_FREQ = 4;
	localparam int POS_C_MODE = 2;
	localparam int POS_C_FREQ = 0;
	localparam int POS_PHASE = 0;
	localparam int POS_A_WARN = 6;
	localparam int POS_B_WARN = 2;
	localparam int POS_C_WARN = 0;
	localparam int POS_LIN_HIGH = 6;
	localparam int POS_LIN_LOW = 1;
	localparam int POS_EXEC = 7;
	localparam int POS_OFF_A = 6;
	localparam int POS_OFF_B = 4;
	localparam int POS_OFF_C = 3;
	localparam int POS_IDLE = 0;
	// writable bits and reset values per slot, slot 7 leftmost
	localparam logic [NUM_REGS-1:0][7:0] REG_WMASK = {8'hDF, 8'hDF,
		8'hDF, 8'hC6, 8'hCF, 8'h01, 8'hFF, 8'hF0};
	localparam logic [NUM_REGS-1:0][7:0] REG_RESET = {8'h00, 8'hD9,
		8'hD1, 8'h42, 8'hCF, 8'h00, 8'h88, 8'h80};
	// millisecond tick timing
	localparam int MS_TIME_NS = 1000000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_CYCLES_DEFAULT = MS_TIME_NS / CLK_PERIOD_NS;
endpackage

// [logic/regulator_mode_and_poweroff_config.sv]
`timescale 1ns/1ps
module regulator_mode_and_poweroff_config import pmic_cfg_pkg::*; #(
	parameter logic DUAL_PHASE_DEFAULT = 1'b0,
	parameter int MS_CYCLES = MS_CYCLES_DEFAULT
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic shutdown_req,
	input wire logic rails_restore,
	output logic [1:0] buck_a_conduction_mode,
	output logic [1:0] buck_a_frequency,
	output logic [1:0] buck_b_conduction_mode,
	output logic [1:0] buck_b_frequency,
	output logic [1:0] buck_c_conduction_mode,
	output logic [1:0] buck_c_frequency,
	output logic phase_combine,
	output logic [1:0] buck_a_warn_threshold,
	output logic [1:0] buck_b_warn_threshold,
	output logic [1:0] buck_c_warn_threshold,
	output logic [1:0] linear_high_voltage_select,
	output logic [1:0] linear_low_voltage_select,
	output logic buck_a_off,
	output logic buck_b_off,
	output logic buck_c_off,
	output logic shutdown_busy,
	output logic shutdown_done,
	output logic [1:0] shutdown_step
);

	localparam int PW = $clog2(MS_CYCLES + 1);
	localparam logic [PW-1:0] TICK_LAST = PW'(MS_CYCLES - 1);

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_APPLY = 4'b0010,
		ST_WAIT = 4'b0100,
		ST_DONE = 4'b1000
	} seq_state_e;

	typedef struct packed {
		logic [NUM_REGS-1:0][7:0] regs;
		logic [7:0] rdata;
		seq_state_e state;
		logic [1:0] step;
		logic [2:0] idle_left;
		logic [PW-1:0] tick_cnt;
		logic [2:0] off;
	} state_s;

	state_s st_r;
	state_s st_nxt;

	// address decode shared by write and read paths
	function automatic logic [3:0] reg_slot(input logic [7:0] a);
		logic [3:0] s;
		s = 4'h0;
		case (a)
			OFS_BUCK_A_MODE_FREQ: s = 4'h8;
			OFS_BUCK_BC_MODE_FREQ: s = 4'h9;
			OFS_PHASE_COMBINE: s = 4'hA;
			OFS_CURRENT_WARN: s = 4'hB;
			OFS_LINEAR_VOLTAGE: s = 4'hC;
			OFS_SHUTDOWN_STEP0: s = 4'hD;
			OFS_SHUTDOWN_STEP1: s = 4'hE;
			OFS_SHUTDOWN_STEP2: s = 4'hF;
			default: s = 4'h0;
		endcase
		return s;
	endfunction

	logic [3:0] wr_slot;
	logic [3:0] rd_slot;
	logic [7:0] step_cfg;
	logic [2:0] step_off;

	assign wr_slot = reg_slot(reg_addr);
	assign rd_slot = reg_slot(reg_addr);
	// configuration byte of the step being worked on
	assign step_cfg = st_r.regs[SLOT_STEP0 + 3'(st_r.step)];
	assign step_off = {step_cfg[POS_OFF_C], step_cfg[POS_OFF_B],
		step_cfg[POS_OFF_A]};

	// next state: register writes, read data and the shutdown sequencer
	always_comb begin
		st_nxt = st_r;
		// reserved bits are masked so they always read zero
		if (reg_wr && wr_slot[3]) begin
			st_nxt.regs[wr_slot[2:0]] = reg_wdata & REG_WMASK[wr_slot[2:0]];
		end
		// unmapped and reserved bytes answer zero
		if (reg_rd) begin
			st_nxt.rdata = rd_slot[3] ? st_r.regs[rd_slot[2:0]] : 8'h00;
		end
		case (st_r.state)
			ST_IDLE: begin
				if (shutdown_req) begin
					st_nxt.state = ST_APPLY;
					st_nxt.step = 2'h0;
				end else if (rails_restore) begin
					st_nxt.off = 3'h0;
				end
			end
			ST_APPLY: begin
				if (step_cfg[POS_EXEC]) begin
					st_nxt.off = st_r.off | step_off;
					st_nxt.idle_left = step_cfg[POS_IDLE+:3];
					st_nxt.tick_cnt = '0;
					st_nxt.state = ST_WAIT;
				end else if (st_r.step == LAST_STEP) begin
					st_nxt.state = ST_DONE;
				end else begin
					st_nxt.step = st_r.step + 2'h1;
				end
			end
			ST_WAIT: begin
				// zero left means the idle has elapsed, so move on now
				if (st_r.idle_left == 3'h0) begin
					if (st_r.step == LAST_STEP) begin
						st_nxt.state = ST_DONE;
					end else begin
						st_nxt.step = st_r.step + 2'h1;
						st_nxt.state = ST_APPLY;
					end
				end else if (st_r.tick_cnt == TICK_LAST) begin
					st_nxt.tick_cnt = '0;
					st_nxt.idle_left = st_r.idle_left - 3'h1;
				end else begin
					st_nxt.tick_cnt = st_r.tick_cnt + PW'(1);
				end
			end
			ST_DONE: begin
				// rails stay off until software brings them back
				if (rails_restore) begin
					st_nxt.off = 3'h0;
					st_nxt.state = ST_IDLE;
				end
			end
			default: st_nxt.state = ST_IDLE;
		endcase
	end

	// one register for all state; variant strap is a build constant
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= '0;
			// the variant strap lands on the low bit of the phase byte
			st_r.regs <= REG_RESET | ({{(8*NUM_REGS-1){1'b0}},
				DUAL_PHASE_DEFAULT} << (16 + POS_PHASE));
			st_r.state <= ST_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// field outputs straight from the register bytes
	assign buck_a_conduction_mode = st_r.regs[0][POS_A_MODE+:2];
	assign buck_a_frequency = st_r.regs[0][POS_A_FREQ+:2];
	assign buck_b_conduction_mode = st_r.regs[1][POS_B_MODE+:2];
	assign buck_b_frequency = st_r.regs[1][POS_B_FREQ+:2];
	assign buck_c_conduction_mode = st_r.regs[1][POS_C_MODE+:2];
	assign buck_c_frequency = st_r.regs[1][POS_C_FREQ+:2];
	assign phase_combine = st_r.regs[2][POS_PHASE];
	assign buck_a_warn_threshold = st_r.regs[3][POS_A_WARN+:2];
	assign buck_b_warn_threshold = st_r.regs[3][POS_B_WARN+:2];
	assign buck_c_warn_threshold = st_r.regs[3][POS_C_WARN+:2];
	assign linear_high_voltage_select = st_r.regs[4][POS_LIN_HIGH+:2];
	assign linear_low_voltage_select = st_r.regs[4][POS_LIN_LOW+:2];

	// read data and sequencer status
	assign reg_rdata = st_r.rdata;
	assign buck_a_off = st_r.off[0];
	assign buck_b_off = st_r.off[1];
	assign buck_c_off = st_r.off[2];
	assign shutdown_busy = (st_r.state == ST_APPLY) ||
		(st_r.state == ST_WAIT);
	assign shutdown_done = (st_r.state == ST_DONE);
	assign shutdown_step = st_r.step;

	// checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	// cycles spent waiting in the current step
	logic [31:0] wait_cycles;
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			wait_cycles <= 32'h0;
		end else if (st_r.state == ST_WAIT) begin
			wait_cycles <= wait_cycles + 32'h1;
		end else begin
			wait_cycles <= 32'h0;
		end
	end

	a_mode_write_a: assert property (
		reg_wr && reg_addr == OFS_BUCK_A_MODE_FREQ |=>
		buck_a_conduction_mode == $past(reg_wdata[7:6]) &&
		buck_a_frequency == $past(reg_wdata[5:4]))
		else $error("buck A mode or frequency not written");

	a_freq_hold_a: assert property (
		!(reg_wr && reg_addr == OFS_BUCK_A_MODE_FREQ) |=>
		$stable(buck_a_frequency))
		else $error("buck A frequency changed without a write");

	bc_field_write_a: assert property (
		reg_wr && reg_addr == OFS_BUCK_BC_MODE_FREQ |=>
		{buck_b_conduction_mode, buck_b_frequency, buck_c_conduction_mode,
		buck_c_frequency} == $past(reg_wdata))
		else $error("buck B or C fields not written");

	phase_write_a: assert property (
		(reg_wr && reg_addr == OFS_PHASE_COMBINE) ##1 !reg_wr ##1
		(reg_rd && reg_addr == OFS_PHASE_COMBINE) |=>
		reg_rdata == {7'h0, $past(reg_wdata[0], 3)})
		else $error("phase select readback wrong");

	warn_write_a: assert property (
		reg_wr && reg_addr == OFS_CURRENT_WARN |=>
		{buck_a_warn_threshold, buck_b_warn_threshold,
		buck_c_warn_threshold} ==
		{$past(reg_wdata[7:6]), $past(reg_wdata[3:0])})
		else $error("warning thresholds not written");

	linear_write_a: assert property (
		reg_wr && reg_addr == OFS_LINEAR_VOLTAGE |=>
		linear_high_voltage_select == $past(reg_wdata[7:6]) &&
		linear_low_voltage_select == $past(reg_wdata[2:1]))
		else $error("linear regulator levels not written");

	rsvd_read_a: assert property (
		reg_rd && reg_addr >= OFS_RSVD_FIRST &&
		reg_addr <= OFS_RSVD_LAST |=> reg_rdata == 8'h00)
		else $error("reserved byte read nonzero");

	skip_step_a: assert property (
		st_r.state == ST_APPLY && !step_cfg[POS_EXEC] |=>
		$stable(st_r.off) && st_r.state != ST_WAIT)
		else $error("skipped step changed rails or waited");

	step_off_a: assert property (
		st_r.state == ST_APPLY && step_cfg[POS_EXEC] |=>
		(st_r.off & $past(step_off)) == $past(step_off) &&
		st_r.state == ST_WAIT)
		else $error("executed step did not turn rails off");

	idle_len_a: assert property (
		st_r.state == ST_WAIT && $past(st_r.state) == ST_WAIT |->
		wait_cycles <= 32'(MS_CYCLES) * 32'd7)
		else $error("idle wait ran past seven milliseconds");

	zero_idle_a: assert property (
		st_r.state == ST_WAIT && st_r.idle_left == 3'h0 |=>
		st_r.state != ST_WAIT || st_r.step != $past(st_r.step))
		else $error("zero idle code added delay");

	step_order_a: assert property (
		shutdown_busy && $past(shutdown_busy) |->
		st_r.step >= $past(st_r.step))
		else $error("shutdown steps ran out of order");

	start_step_a: assert property (
		st_r.state == ST_IDLE && shutdown_req |=>
		st_r.state == ST_APPLY && st_r.step == 2'h0)
		else $error("shutdown did not start at step 0");

	// each field holds between writes to its own byte
	a_mode_hold_a: assert property (
		!(reg_wr && reg_addr == OFS_BUCK_A_MODE_FREQ) |=>
		$stable(buck_a_conduction_mode))
		else $error("buck A mode changed without a write");

	bc_field_hold_a: assert property (
		!(reg_wr && reg_addr == OFS_BUCK_BC_MODE_FREQ) |=>
		$stable({buck_b_conduction_mode, buck_b_frequency,
		buck_c_conduction_mode, buck_c_frequency}))
		else $error("buck B or C fields changed without a write");

	phase_hold_a: assert property (
		!(reg_wr && reg_addr == OFS_PHASE_COMBINE) |=>
		$stable(phase_combine))
		else $error("phase select changed without a write");

	warn_hold_a: assert property (
		!(reg_wr && reg_addr == OFS_CURRENT_WARN) |=>
		$stable({buck_a_warn_threshold, buck_b_warn_threshold,
		buck_c_warn_threshold}))
		else $error("warning thresholds changed without a write");

	linear_hold_a: assert property (
		!(reg_wr && reg_addr == OFS_LINEAR_VOLTAGE) |=>
		$stable({linear_high_voltage_select, linear_low_voltage_select}))
		else $error("linear levels changed without a write");

	rsvd_write_a: assert property (
		reg_wr && reg_addr >= OFS_RSVD_FIRST &&
		reg_addr <= OFS_RSVD_LAST |=> $stable(st_r.regs))
		else $error("reserved byte write changed a register");

	// rails never come back on while the sequencer runs
	off_sticky_a: assert property (
		shutdown_busy |=> (st_r.off & $past(st_r.off)) == $past(st_r.off))
		else $error("rail turned back on during shutdown");

	restore_a: assert property (
		shutdown_done && rails_restore |=>
		st_r.off == 3'h0 && st_r.state == ST_IDLE)
		else $error("restore left rails off");

	idle_tick_a: assert property (
		st_r.state == ST_WAIT && st_r.idle_left != 3'h0 &&
		st_r.tick_cnt == TICK_LAST |=>
		st_r.idle_left == $past(st_r.idle_left) - 3'h1)
		else $error("idle count missed a millisecond tick");

	// the last step must read its own configuration byte
	last_step_a: assert property (
		st_r.state == ST_APPLY && st_r.step == LAST_STEP &&
		st_r.regs[NUM_REGS-1][POS_EXEC] |=>
		st_r.state == ST_WAIT &&
		st_r.idle_left == $past(st_r.regs[NUM_REGS-1][POS_IDLE+:3]))
		else $error("last step did not use its own byte");

	done_hold_a: assert property (
		shutdown_done && !rails_restore |=> shutdown_done)
		else $error("done dropped without a restore");

	// scenario covers
	done_cover: cover property (
		st_r.state == ST_WAIT ##1 st_r.state == ST_DONE);
	skip_cover: cover property (
		st_r.state == ST_APPLY && !step_cfg[POS_EXEC]);
	wait_cover: cover property (
		st_r.state == ST_WAIT && st_r.tick_cnt == TICK_LAST);
	restore_cover: cover property (
		shutdown_done && rails_restore);
	last_step_cover: cover property (
		st_r.state == ST_APPLY && st_r.step == LAST_STEP &&
		st_r.regs[NUM_REGS-1][POS_EXEC]);

endmodule // regulator_mode_and_poweroff_config
